// *** common/t1_alarm_consts.svh ***
// Constants for the T1 receive alarm and status block.
// Included by the alarm status design file only, not by the package; definitions only.
`ifndef T1_ALARM_CONSTS_SVH
`define T1_ALARM_CONSTS_SVH

// Status register offset and bit positions
`define STATUS_ONE_ADDR     8'h20
`define BIT_LOOP_UP         7
`define BIT_LOOP_DOWN       6
`define BIT_TX_CLOCK_LOST   5
`define BIT_STORE_SLIP      4
`define BIT_BLUE            3
`define BIT_YELLOW          2
`define BIT_CARRIER_LOSS    1
`define BIT_SYNC_LOSS       0

// Timing
`define CLK_PERIOD_NS       25
`define TX_CLOCK_LOSS_NS    5200
`define TX_LOSS_CYCLES      (`TX_CLOCK_LOSS_NS / `CLK_PERIOD_NS)
`define BLUE_WINDOW_MS      3
`define BLUE_WINDOW_CYCLES  (`BLUE_WINDOW_MS * 1000000 / `CLK_PERIOD_NS)

// Alarm thresholds
`define BLUE_MAX_ZEROS      3'h5
`define BLUE_CLEAR_ZEROS    3'h6
`define BIT2_WINDOW_LAST    9'h0ff
`define BIT2_SET_ZEROS      9'h0fe
`define ESF_SET_RUN         5'h10
`define ESF_WINDOW_LAST     4'hf
`define ESF_CLEAR_MAX       5'h0e
`define RED_SET_ZEROS       8'hc0
`define RED_WINDOW_BITS     7'h70
`define RED_CLEAR_ONES      4'he

`endif

// *** common/t1_alarm_pkg.sv ***
// Types for the T1 receive alarm and status block.
// Needs nothing else.
package t1_alarm_pkg;

   typedef enum logic [1:0] {
      CARRIER_OK,
      CARRIER_LOST,
      CARRIER_RECOVER
   } red_state_type;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_type;

   typedef struct packed {
      red_state_type red;
      logic [7:0]    zero_run;
      logic [6:0]    red_bits;
      logic [3:0]    red_ones;
      logic [16:0]   blue_timer;
      logic [2:0]    blue_zeros;
      logic [8:0]    chan_count;
      logic [8:0]    bit2_zeros;
      logic [1:0]    fbit_hist;
      logic [4:0]    esf_run;
      logic [3:0]    esf_win;
      logic [4:0]    esf_hits;
      logic [7:0]    tx_idle;
      logic          lost_tx;
      logic          slip;
      logic          blue;
      logic          yel_bit2;
      logic          yel_fbit;
      logic          yel_esf;
      logic          sync_loss;
      logic          loop_up;
      logic          loop_down;
      logic [7:0]    rd_data;
      logic          pin;
      logic          fallback;
   } alarm_state_type;

endpackage : t1_alarm_pkg

// *** rtl/edge_sampler.sv ***
// Two-flop synchroniser for one pin with a rising-edge detector.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/100ps
module edge_sampler (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Pin and results
   input  wire logic pin_in,
   output      logic level,
   output      logic rise
);
   t1_alarm_pkg::sync_state_type st;
   t1_alarm_pkg::sync_state_type next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.s2;
   assign rise  = st.s2 & ~st.s3;
endmodule : edge_sampler

// *** rtl/t1_rx_alarm_status.sv ***
// Receive alarm detection and the alarm status register of a T1 framer.
// Framer, elastic store and loop-code detector sit outside on clk_sys.
//
// Notes on behaviour
// (RULE1) Loop-up bit follows loop-up code reception
// (RULE2) Loop-down bit follows loop-down code reception
// (RULE3) Transmit clock idle 5.2 us sets loss
// (RULE4) Enabled shared pin goes high on loss
// (RULE5) Fallback enabled moves transmit to receive clock
// (RULE6) Slip bit set on frame repeat or delete
// (RULE7) Blue: 3 ms window, <=5 zeros set, >=6 clear
// (RULE8) Bit-2 yellow: 254 of 256 channels zero
// (RULE9) F-bit yellow: two ones set, two zeros clear
// (RULE10) ESF yellow: 16 00FF set, <=14 clears
// (RULE11) Red: 192 zeros set; 14 ones/112 clear
// (RULE12) Sync loss bit while framer unsynchronised
// (RULE13) Blue window tolerates errors, ignores framed ones
// (RULE14) Host should qualify blue with sync loss
// (RULE15) Status bits show present condition, not latched
`timescale 1ns/100ps
`include "t1_alarm_consts.svh"
module t1_rx_alarm_status #(
   parameter int unsigned BLUE_WINDOW_CYCLES = `BLUE_WINDOW_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // Line pins
   input  wire logic       transmit_clock_in,
   input  wire logic       rx_clock_in,
   input  wire logic       rx_positive_in,
   input  wire logic       rx_negative_in,
   // Framer events on clk_sys
   input  wire logic       loop_up_match,
   input  wire logic       loop_down_match,
   input  wire logic       store_slip_event,
   input  wire logic       framer_in_sync,
   input  wire logic       chan_strobe,
   input  wire logic       chan_bit2,
   input  wire logic       fbit12_strobe,
   input  wire logic       fbit12_value,
   input  wire logic       fdl_pattern_strobe,
   input  wire logic       fdl_pattern_match,
   // Mode bits
   input  wire logic       esf_mode,
   input  wire logic       yellow_mode_select,
   input  wire logic       sync_clock_pin_enable,
   input  wire logic       clock_fallback_enable,
   // Read port
   input  wire logic       rd_strobe,
   input  wire logic [7:0] rd_addr,
   output      logic [7:0] rd_data,
   // Pins out
   output      logic       sync_clock_loss_pin,
   output      logic       tx_clock_from_rx
);
   t1_alarm_pkg::alarm_state_type st;
   t1_alarm_pkg::alarm_state_type next_st;

   logic [3:0] pin_raw;
   logic [3:0] pin_level;
   logic [3:0] pin_rise;
   logic       rx_bit;
   logic       rx_zero;
   logic       tx_edge;
   logic       yellow;
   logic       red_alarm;
   logic [7:0] status_word;

   function automatic logic line_zero(input logic pos, input logic neg);
      line_zero = ~pos & ~neg;
   endfunction : line_zero

   // Pin synchronisers
   assign pin_raw = {rx_negative_in, rx_positive_in, rx_clock_in, transmit_clock_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         edge_sampler u_sync (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .pin_in  (pin_raw[gi]),
            .level   (pin_level[gi]),
            .rise    (pin_rise[gi])
         );
      end
   endgenerate

   assign tx_edge = pin_rise[0];
   assign rx_bit  = pin_rise[1];
   assign rx_zero = line_zero(pin_level[2], pin_level[3]);

   assign yellow    = esf_mode ? st.yel_esf :
                      (yellow_mode_select ? st.yel_fbit : st.yel_bit2);
   assign red_alarm = (st.red != t1_alarm_pkg::CARRIER_OK);

   // Present-state status word
   always_comb begin
      status_word                      = '0;
      status_word[`BIT_LOOP_UP]        = st.loop_up;
      status_word[`BIT_LOOP_DOWN]      = st.loop_down;
      status_word[`BIT_TX_CLOCK_LOST]  = st.lost_tx;
      status_word[`BIT_STORE_SLIP]     = st.slip;
      status_word[`BIT_BLUE]           = st.blue;
      status_word[`BIT_YELLOW]         = yellow;
      status_word[`BIT_CARRIER_LOSS]   = red_alarm;
      status_word[`BIT_SYNC_LOSS]      = st.sync_loss;
   end

   always_comb begin
      next_st = st;
      // Level conditions follow their sources
      next_st.loop_up   = loop_up_match; // RULE1 RULE15
      next_st.loop_down = loop_down_match; // RULE2 RULE15
      next_st.slip      = store_slip_event; // RULE6 RULE15
      next_st.sync_loss = ~framer_in_sync; // RULE12

      // Transmit clock watchdog
      if (tx_edge) begin
         next_st.tx_idle = '0;
         next_st.lost_tx = 1'b0;
      end else if (st.tx_idle == 8'(`TX_LOSS_CYCLES - 1)) begin
         next_st.lost_tx = 1'b1; // RULE3
      end else begin
         next_st.tx_idle = st.tx_idle + 8'h01;
      end
      next_st.pin      = sync_clock_pin_enable ? st.lost_tx : st.sync_loss; // RULE4
      next_st.fallback = clock_fallback_enable & st.lost_tx; // RULE5

      // Blue alarm over a fixed window
      if (rx_bit && rx_zero && st.blue_zeros != `BLUE_CLEAR_ZEROS) begin
         next_st.blue_zeros = st.blue_zeros + 3'h1;
      end
      if (st.blue_timer == 17'(BLUE_WINDOW_CYCLES - 1)) begin
         next_st.blue       = (next_st.blue_zeros <= `BLUE_MAX_ZEROS); // RULE7 RULE13
         next_st.blue_timer = '0;
         next_st.blue_zeros = '0;
      end else begin
         next_st.blue_timer = st.blue_timer + 17'h00001;
      end

      // Bit-2 yellow over 256 channels
      if (chan_strobe) begin
         next_st.bit2_zeros = st.bit2_zeros + {8'h00, ~chan_bit2};
         if (st.chan_count == `BIT2_WINDOW_LAST) begin
            next_st.yel_bit2   = (next_st.bit2_zeros >= `BIT2_SET_ZEROS); // RULE8
            next_st.chan_count = '0;
            next_st.bit2_zeros = '0;
         end else begin
            next_st.chan_count = st.chan_count + 9'h001;
         end
      end

      // Twelfth F-bit yellow
      if (fbit12_strobe) begin
         next_st.fbit_hist = {st.fbit_hist[0], fbit12_value};
         if (st.fbit_hist[0] && fbit12_value) begin
            next_st.yel_fbit = 1'b1; // RULE9
         end else if (!st.fbit_hist[0] && !fbit12_value) begin
            next_st.yel_fbit = 1'b0; // RULE9
         end
      end

      // ESF data-link yellow
      if (fdl_pattern_strobe) begin
         if (!st.yel_esf) begin
            next_st.esf_run = fdl_pattern_match ? st.esf_run + 5'h01 : 5'h00;
            if (next_st.esf_run == `ESF_SET_RUN) begin
               next_st.yel_esf  = 1'b1; // RULE10
               next_st.esf_win  = '0;
               next_st.esf_hits = '0;
            end
         end else begin
            next_st.esf_hits = st.esf_hits + {4'h0, fdl_pattern_match};
            if (st.esf_win == `ESF_WINDOW_LAST) begin
               if (next_st.esf_hits <= `ESF_CLEAR_MAX) begin
                  next_st.yel_esf = 1'b0; // RULE10
                  next_st.esf_run = '0;
               end
               next_st.esf_win  = '0;
               next_st.esf_hits = '0;
            end else begin
               next_st.esf_win = st.esf_win + 4'h1;
            end
         end
      end

      // Red alarm, carrier loss
      if (rx_bit) begin
         case (st.red)
            t1_alarm_pkg::CARRIER_OK: begin
               if (!rx_zero) begin
                  next_st.zero_run = '0;
               end else if (st.zero_run == `RED_SET_ZEROS - 8'h01) begin
                  next_st.red = t1_alarm_pkg::CARRIER_LOST; // RULE11
               end else begin
                  next_st.zero_run = st.zero_run + 8'h01;
               end
            end
            t1_alarm_pkg::CARRIER_LOST: begin
               if (!rx_zero) begin
                  next_st.red      = t1_alarm_pkg::CARRIER_RECOVER;
                  next_st.red_bits = 7'h01;
                  next_st.red_ones = 4'h1;
               end
            end
            t1_alarm_pkg::CARRIER_RECOVER: begin
               next_st.red_bits = st.red_bits + 7'h01;
               next_st.red_ones = st.red_ones + {3'h0, ~rx_zero};
               if (next_st.red_ones == `RED_CLEAR_ONES) begin
                  next_st.red      = t1_alarm_pkg::CARRIER_OK; // RULE11
                  next_st.zero_run = '0;
               end else if (next_st.red_bits == `RED_WINDOW_BITS) begin
                  next_st.red = t1_alarm_pkg::CARRIER_LOST; // RULE11
               end
            end
            default: begin
               next_st.red = t1_alarm_pkg::CARRIER_OK;
            end
         endcase
      end

      // Register read
      if (rd_strobe) begin
         next_st.rd_data = (rd_addr == `STATUS_ONE_ADDR) ? status_word : 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st     <= '0;
         st.red <= t1_alarm_pkg::CARRIER_OK;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data             = st.rd_data;
   assign sync_clock_loss_pin = st.pin;
   assign tx_clock_from_rx    = st.fallback;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   loop_up_a: assert property (loop_up_match |=> st.loop_up ##1 1'b1) // RULE1
      else $error("loop-up bit did not follow match");
   loop_down_a: assert property (!loop_down_match |=> !st.loop_down) // RULE2
      else $error("loop-down bit set without match");
   tx_loss_a: assert property ($rose(st.lost_tx) |-> $past(st.tx_idle) == 8'(`TX_LOSS_CYCLES - 1)) // RULE3
      else $error("transmit clock loss at wrong count");
   pin_follow_a: assert property (sync_clock_pin_enable && st.lost_tx |=> sync_clock_loss_pin) // RULE4
      else $error("shared pin not high on clock loss");
   fallback_a: assert property (st.lost_tx && clock_fallback_enable |=> tx_clock_from_rx) // RULE5
      else $error("fallback not taken");
   slip_bit_a: assert property (store_slip_event ##1 rd_strobe && rd_addr == `STATUS_ONE_ADDR
      |=> rd_data[`BIT_STORE_SLIP]) // RULE6
      else $error("slip not reported");
   red_set_a: assert property (st.red == t1_alarm_pkg::CARRIER_OK && rx_bit && rx_zero
      && st.zero_run == `RED_SET_ZEROS - 8'h01 |=> red_alarm) // RULE11
      else $error("carrier loss not set at 192 zeros");
   sync_loss_a: assert property (!framer_in_sync |=> st.sync_loss) // RULE12
      else $error("sync loss bit not set");
   fbit_yellow_a: assert property (fbit12_strobe && fbit12_value && st.fbit_hist[0]
      |=> st.yel_fbit) // RULE9
      else $error("F-bit yellow not set after two ones");
endmodule : t1_rx_alarm_status

// *** verif/t1_line_model.sv ***
// Line-side model: transmit clock, recovered receive clock and AMI rails.
// Assumes the bench drives tx_run and rx_mark; receive clock free-running, transmit clock gated by tx_run.
`timescale 1ns/100ps
module t1_line_model (
   // Controls
   input  wire logic tx_run,
   input  wire logic rx_mark,
   // Line pins
   output      logic transmit_clock_in,
   output      logic rx_clock_in,
   output      logic rx_positive_in,
   output      logic rx_negative_in
);
   logic pol;

   // Transmit clock halts at its level when stopped
   initial begin
      transmit_clock_in = 1'b0;
      #41;
      forever #100 if (tx_run) transmit_clock_in = ~transmit_clock_in;
   end

   // Rails change on the falling edge; polarity alternates every bit, not every mark
   initial begin
      {rx_clock_in, rx_positive_in, rx_negative_in, pol} = 4'h0;
      #37;
      forever begin
         #100 rx_clock_in = 1'b1;
         #100 rx_clock_in = 1'b0;
         pol = ~pol;
         rx_positive_in = rx_mark & pol;
         rx_negative_in = rx_mark & ~pol;
      end
   end
endmodule : t1_line_model

// *** verif/tb.sv ***
// Self-checking bench for the T1 receive alarm and status block.
// Assumes the line model is compiled first; blue window shortened to 200.
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic       lu;
      logic       ld;
      logic       sy;
      logic [7:0] exp;
   } row_type;
   localparam row_type ROWS [6] = '{'{0, 0, 1, 8'h00}, '{1, 0, 1, 8'h80},
      '{0, 1, 1, 8'h40}, '{1, 1, 0, 8'hc1}, '{0, 0, 0, 8'h01}, '{0, 0, 1, 8'h00}};
   logic       clk_sys, nrst, tx_run, rx_mark, transmit_clock_in, rx_clock_in;
   logic       rx_positive_in, rx_negative_in, lu, ld, slip, sy, esf, ysel, pen, fb;
   logic [2:0] strb, val;
   logic       rd_strobe, pin, tfr;
   logic [7:0] rd_addr, rd_data, v;
   int         fail_count, cmp_count, i;

   t1_line_model line (.tx_run, .rx_mark, .transmit_clock_in, .rx_clock_in,
      .rx_positive_in, .rx_negative_in);

   t1_rx_alarm_status #(.BLUE_WINDOW_CYCLES(200)) dut (.clk_sys, .nrst,
      .transmit_clock_in, .rx_clock_in, .rx_positive_in, .rx_negative_in,
      .loop_up_match(lu), .loop_down_match(ld), .store_slip_event(slip),
      .framer_in_sync(sy), .chan_strobe(strb[0]), .chan_bit2(val[0]),
      .fbit12_strobe(strb[1]), .fbit12_value(val[1]), .fdl_pattern_strobe(strb[2]),
      .fdl_pattern_match(val[2]), .esf_mode(esf), .yellow_mode_select(ysel),
      .sync_clock_pin_enable(pen), .clock_fallback_enable(fb), .rd_strobe,
      .rd_addr, .rd_data, .sync_clock_loss_pin(pin), .tx_clock_from_rx(tfr));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      rd_strobe <= 1'b1;
      rd_addr   <= a;
      @(posedge clk_sys);
      rd_strobe <= 1'b0;
      @(posedge clk_sys);
      #1 v = rd_data;
   endtask : rd

   task automatic st(input logic [7:0] mask, input logic [7:0] exp);
      rd(8'h20);
      chk(v & mask, exp);
   endtask : st

   task automatic evt(input int k, input logic b, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         strb[k] <= 1'b1;
         val[k]  <= b;
         @(posedge clk_sys);
         strb[k] <= 1'b0;
      end
   endtask : evt

   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   initial begin
      #1ms;
      fail_count++;
      summarize();
   end

   initial begin
      {nrst, lu, ld, slip, sy, esf, ysel, pen, fb, rd_strobe} = 10'h0;
      {strb, val, rd_addr} = 14'h0;
      {tx_run, rx_mark, fail_count, cmp_count} = {2'b11, 64'h0};
      #30 chk(rd_data, 8'h00);
      chk({6'h00, pin, tfr}, 8'h00);
      @(posedge clk_sys);
      @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // Framer level rows
      foreach (ROWS[r]) begin
         lu <= ROWS[r].lu;
         ld <= ROWS[r].ld;
         sy <= ROWS[r].sy;
         st(8'hc1, ROWS[r].exp);
      end
      // Unmapped address reads zero, after a read that left data up
      sy <= 1'b0;
      st(8'h01, 8'h01);
      chk({7'h00, pin}, 8'h01);
      rd(8'h21);
      chk(v, 8'h00);
      sy <= 1'b1;
      // Slip seen only by a read right after the event
      @(posedge clk_sys) slip <= 1'b1;
      @(posedge clk_sys) begin
         slip      <= 1'b0;
         rd_strobe <= 1'b1;
         rd_addr   <= 8'h20;
      end
      @(posedge clk_sys) rd_strobe <= 1'b0;
      @(posedge clk_sys) #1 chk(rd_data & 8'h10, 8'h10);
      st(8'h10, 8'h00);
      // Transmit clock loss, pin and fallback
      pen    <= 1'b1;
      fb     <= 1'b1;
      tx_run <= 1'b0;
      for (i = 0; i < 300 && pin !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk(8'((i >= 185) && (i <= 220)), 8'h01);
      #1 chk({7'h00, tfr}, 8'h01);
      st(8'h20, 8'h20);
      fb  <= 1'b0;
      pen <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({6'h00, pin, tfr}, 8'h00);
      tx_run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      st(8'h20, 8'h00);
      // Carrier loss and blue clear on zeros
      rx_mark <= 1'b0;
      repeat (1440) @(posedge clk_sys);
      st(8'h02, 8'h00);
      repeat (200) @(posedge clk_sys);
      st(8'h0a, 8'h02);
      // Sparse ones, one in nine bits, never reach 14 in a window
      repeat (30) begin
         rx_mark <= 1'b1;
         repeat (8) @(posedge clk_sys);
         rx_mark <= 1'b0;
         repeat (64) @(posedge clk_sys);
      end
      repeat (900) @(posedge clk_sys);
      st(8'h02, 8'h02);
      rx_mark <= 1'b1;
      repeat (80) @(posedge clk_sys);
      st(8'h02, 8'h02);
      repeat (100) @(posedge clk_sys);
      st(8'h02, 8'h00);
      repeat (400) @(posedge clk_sys);
      st(8'h09, 8'h08);
      // Yellow, bit-2 mode
      evt(0, 1'b0, 254);
      evt(0, 1'b1, 2);
      st(8'h04, 8'h04);
      evt(0, 1'b0, 253);
      evt(0, 1'b1, 3);
      st(8'h04, 8'h00);
      // Yellow, F-bit mode
      ysel <= 1'b1;
      evt(1, 1'b1, 1);
      st(8'h04, 8'h00);
      evt(1, 1'b1, 1);
      st(8'h04, 8'h04);
      evt(1, 1'b0, 1);
      st(8'h04, 8'h04);
      evt(1, 1'b0, 1);
      st(8'h04, 8'h00);
      // Yellow, extended superframe mode
      esf <= 1'b1;
      evt(2, 1'b1, 15);
      st(8'h04, 8'h00);
      evt(2, 1'b1, 1);
      st(8'h04, 8'h04);
      evt(2, 1'b1, 15);
      evt(2, 1'b0, 1);
      st(8'h04, 8'h04);
      evt(2, 1'b1, 14);
      evt(2, 1'b0, 2);
      st(8'h04, 8'h00);
      summarize();
   end
endmodule : tb
